// ### include/phy_ctl_regs.vh
/*
 Register offsets, field positions, reset values and timing counts for the PHY status and control bank.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PHY_CTL_REGS_VH
`define PHY_CTL_REGS_VH

`define ADDR_CTRL          12'h000
`define ADDR_FLAGS         12'h004
`define ADDR_SELECT        12'h008
`define ADDR_STATUS        12'h00C

`define CTRL_SHORT_RST     0
`define CTRL_FAST_ARB      1
`define CTRL_MIXED_SPEED   2
`define CTRL_RESUME_EN     3

`define FLAG_LOOP          0
`define FLAG_PWR_DROP      1
`define FLAG_EXPIRY        2
`define FLAG_PORT_CHG      3

`define SEL_PAGE_LSB       0
`define SEL_PAGE_MSB       2
`define SEL_PORT_LSB       4
`define SEL_PORT_MSB       7

`define STAT_SHORT_BUSY    0
`define STAT_LINK_WAKE     1
`define STAT_PWR_SENSE     2
`define STAT_BUS_RESET     3

`define SHORT_RST_NS       1300
`define CLK_PERIOD_NS      8
`define ZERO32             32'h00000000
`define ZERO4              4'h0
`define ZERO3              3'h0

`endif

// ### src/phy_ctl_bank.v
/*
 PHY base status and control bits behind an APB slave: short reset request, sticky flags, enables, page and port select.
 Assumes synchronous inputs, one clock, APB master per protocol; zero-wait answers.
*/
// Implementation choices: the address map and register access over APB.
// Overview of operation
// [R01] Writing 1 to the short reset request starts a 1.3 us arbitrated bus reset at the next opportunity.
// [R02] Any bus reset returns the short reset request bit to 0.
// [R03] An arbitration time-out at tree-ID start sets the cycle topology flag, cleared by reset or writing 1.
// [R04] Cycle topology flag with resume notify enable wakes the link layer when it is or becomes inactive.
// [R05] A non-loop node timing out on tree-ID or self-ID sets the state expiry flag and does a bus reset.
// [R06] Each fall of cable power sense sets the cable power drop flag, cleared by reset or writing 1.
// [R07] A state time-out sets the state expiry flag and causes a bus reset; cleared by reset or writing 1.
// [R08] Bias, connect, disable or fault changes on an enabled port set the port change flag; bias only if enabled.
// [R09] With resume notify enable set, resume start on any port also sets the port change flag.
// [R10] The fast arbitration enable gates accelerated arbitration; reset clears it, bus reset does not.
// [R11] The mixed speed enable permits mixed-speed concatenation; reset clears it, bus reset does not.
// [R12] The 3-bit page select chooses the page for addresses 8 to 15; reset clears it, bus reset does not.
// [R13] The 4-bit port select picks the port from 0 for per-port accesses; reset clears it only.
// [R14] Resume notify enable gates resume events into the port change flag; reset clears it only.
// [R15] Writing 0 to a flag keeps it, and a hardware set beats a same-cycle clear.
`timescale 1ns/10ps
`include "phy_ctl_regs.vh"
module phy_ctl_bank #(
   parameter NPORTS   = 3,
   parameter SHORT_CW = 8
) (
   input  wire              clk,
   input  wire              rst,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   input  wire              cable_power_sense,
   input  wire              tree_start_timeout,
   input  wire              state_timeout,
   input  wire              bus_idle,
   input  wire              link_layer_active,
   input  wire              other_bus_reset,
   input  wire [NPORTS-1:0] port_int_enable,
   input  wire [NPORTS-1:0] port_bias,
   input  wire [NPORTS-1:0] port_connected,
   input  wire [NPORTS-1:0] port_disabled,
   input  wire [NPORTS-1:0] port_fault,
   input  wire [NPORTS-1:0] port_resume_start,
   output reg               bus_reset_out,
   output reg               short_reset_active,
   output reg               link_layer_wake,
   output reg               fast_arb_en,
   output reg               mixed_speed_en,
   output reg  [2:0]        page_select,
   output reg  [3:0]        port_select
);
   localparam SHORT_CYC = (`SHORT_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   reg              short_req_reg;
   reg              resume_en_reg;
   reg              loop_reg;
   reg              pwr_drop_reg;
   reg              expiry_reg;
   reg              port_chg_reg;
   reg [NPORTS-1:0] bias_last_reg;
   reg [NPORTS-1:0] con_last_reg;
   reg [NPORTS-1:0] dis_last_reg;
   reg [NPORTS-1:0] fault_last_reg;

   wire        pwr_fall;
   wire        short_busy;
   wire        short_done;
   wire        setup_ph  = psel && !penable;
   wire        wr_take   = psel && penable && pwrite;
   wire        short_go  = short_req_reg && bus_idle && !short_busy;
   wire        any_reset = short_done || state_timeout || other_bus_reset;

   function hit;
      input [11:0] a;
      input [11:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // Clear only on a written 1 and when no set arrives
   function sticky_next;
      input cur;
      input set;
      input clr_write;
      input wbit;
      begin
         sticky_next = set | (cur & ~(clr_write & wbit));
      end
   endfunction

   phy_edge_det u_pwr_edge (
      .clk        (clk),
      .rst        (rst),
      .level_in   (cable_power_sense),
      .fall_pulse (pwr_fall)
   );

   phy_short_reset #(
      .CYCLES (SHORT_CYC),
      .CW     (SHORT_CW)
   ) u_short (
      .clk   (clk),
      .rst   (rst),
      .start (short_go),
      .busy  (short_busy),
      .done  (short_done)
   );

   wire [NPORTS-1:0] chg_vec = port_int_enable &
                               (((port_bias ^ bias_last_reg) & ~port_disabled) |
                                (port_connected ^ con_last_reg) |
                                (port_disabled ^ dis_last_reg) |
                                (port_fault ^ fault_last_reg)); // [R08]
   wire port_set = (|chg_vec) || (resume_en_reg && (|port_resume_start)); // [R09] [R14]
   wire wr_flags = wr_take && hit(paddr, `ADDR_FLAGS);
   wire wr_ctrl  = wr_take && hit(paddr, `ADDR_CTRL);
   wire wr_sel   = wr_take && hit(paddr, `ADDR_SELECT);

   always @(posedge clk) begin
      // Trackers follow the pins in reset too: no false port event at release
      bias_last_reg  <= port_bias;
      con_last_reg   <= port_connected;
      dis_last_reg   <= port_disabled;
      fault_last_reg <= port_fault;
      if (rst) begin
         short_req_reg  <= 1'b0;
         resume_en_reg  <= 1'b0;
         loop_reg       <= 1'b0;
         pwr_drop_reg   <= 1'b0;
         expiry_reg     <= 1'b0;
         port_chg_reg   <= 1'b0;
         fast_arb_en    <= 1'b0;
         mixed_speed_en <= 1'b0;
         page_select    <= `ZERO3;
         port_select    <= `ZERO4;
      end else begin
         // Bus reset wins over a same-cycle request write
         if (any_reset)
            short_req_reg <= 1'b0; // [R02]
         else if (wr_ctrl && pwdata[`CTRL_SHORT_RST])
            short_req_reg <= 1'b1; // [R01]
         if (wr_ctrl) begin
            fast_arb_en    <= pwdata[`CTRL_FAST_ARB]; // [R10]
            mixed_speed_en <= pwdata[`CTRL_MIXED_SPEED]; // [R11]
            resume_en_reg  <= pwdata[`CTRL_RESUME_EN]; // [R14]
         end
         if (wr_sel) begin
            page_select <= pwdata[`SEL_PAGE_MSB:`SEL_PAGE_LSB]; // [R12]
            port_select <= pwdata[`SEL_PORT_MSB:`SEL_PORT_LSB]; // [R13]
         end
         loop_reg     <= sticky_next(loop_reg, tree_start_timeout, wr_flags, pwdata[`FLAG_LOOP]); // [R03] [R15]
         pwr_drop_reg <= sticky_next(pwr_drop_reg, pwr_fall, wr_flags, pwdata[`FLAG_PWR_DROP]); // [R06] [R15]
         expiry_reg   <= sticky_next(expiry_reg, state_timeout, wr_flags, pwdata[`FLAG_EXPIRY]); // [R05] [R07]
         port_chg_reg <= sticky_next(port_chg_reg, port_set, wr_flags, pwdata[`FLAG_PORT_CHG]); // [R15]
      end
   end

   // Registered outputs; bus reset pulse one cycle after its cause
   always @(posedge clk) begin
      if (rst) begin
         bus_reset_out      <= 1'b0;
         short_reset_active <= 1'b0;
         link_layer_wake    <= 1'b0;
      end else begin
         bus_reset_out      <= any_reset; // [R05] [R07]
         short_reset_active <= short_busy || short_go; // [R01]
         // Wake held while condition stands and link stays asleep
         link_layer_wake    <= loop_reg && resume_en_reg && !link_layer_active; // [R04]
      end
   end

   // Zero-wait APB: ready in every access cycle, data latched in setup
   always @(posedge clk) begin
      if (rst) begin
         prdata  <= `ZERO32;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_ph;
         pslverr <= 1'b0;
         if (setup_ph) begin
            prdata <= `ZERO32;
            if (hit(paddr, `ADDR_CTRL)) begin
               prdata[`CTRL_SHORT_RST]   <= short_req_reg;
               prdata[`CTRL_FAST_ARB]    <= fast_arb_en;
               prdata[`CTRL_MIXED_SPEED] <= mixed_speed_en;
               prdata[`CTRL_RESUME_EN]   <= resume_en_reg;
            end else if (hit(paddr, `ADDR_FLAGS)) begin
               prdata[`FLAG_LOOP]     <= loop_reg;
               prdata[`FLAG_PWR_DROP] <= pwr_drop_reg;
               prdata[`FLAG_EXPIRY]   <= expiry_reg;
               prdata[`FLAG_PORT_CHG] <= port_chg_reg;
            end else if (hit(paddr, `ADDR_SELECT)) begin
               prdata[`SEL_PAGE_MSB:`SEL_PAGE_LSB] <= page_select;
               prdata[`SEL_PORT_MSB:`SEL_PORT_LSB] <= port_select;
            end else if (hit(paddr, `ADDR_STATUS)) begin
               prdata[`STAT_SHORT_BUSY] <= short_busy;
               prdata[`STAT_LINK_WAKE]  <= link_layer_wake;
               prdata[`STAT_PWR_SENSE]  <= cable_power_sense;
               prdata[`STAT_BUS_RESET]  <= bus_reset_out;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule // phy_ctl_bank

// ### src/phy_edge_det.v
/*
 Event detector: pulses on a falling edge of a synchronous level.
 Assumes the input is already synchronous to clk.
*/
`timescale 1ns/10ps
module phy_edge_det (
   input  wire clk,
   input  wire rst,
   input  wire level_in,
   output wire fall_pulse
);
   reg last_reg;

   // Follows the pin in reset too, so a low level at release is no drop
   always @(posedge clk) begin
      last_reg <= level_in;
   end

   // No pulse while in reset
   assign fall_pulse = last_reg & ~level_in & ~rst;
endmodule // phy_edge_det

// ### src/phy_short_reset.v
/*
 Short arbitrated bus reset timer.
 Assumes start is a one-cycle pulse taken only while idle and bus free.
*/
`timescale 1ns/10ps
`include "phy_ctl_regs.vh"
module phy_short_reset #(
   parameter CYCLES = 163,
   parameter CW     = 8
) (
   input  wire clk,
   input  wire rst,
   input  wire start,
   output wire busy,
   output wire done
);
   reg [CW-1:0] cnt_reg;
   reg          busy_reg;

   always @(posedge clk) begin
      if (rst) begin
         cnt_reg  <= {CW{1'b0}};
         busy_reg <= 1'b0;
      end else if (start && !busy_reg) begin
         cnt_reg  <= CYCLES[CW-1:0] - 1'b1;
         busy_reg <= 1'b1;
      end else if (busy_reg) begin
         if (cnt_reg == {CW{1'b0}})
            busy_reg <= 1'b0;
         else
            cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign busy = busy_reg;
   assign done = busy_reg && (cnt_reg == {CW{1'b0}});
endmodule // phy_short_reset

// ### tb/link_layer_model.sv
/* Link layer partner: sleeps while asked, wakes on the PHY's wake request.
   Assumes bench-driven sleep request on the same clock. */
`timescale 1ns/10ps
module link_layer_model (
   input  logic clk,
   input  logic rst,
   input  logic sleep_req,
   input  logic link_layer_wake,
   output logic link_layer_active
);
   // A held sleep request outranks the wake, so wake stays visible
   // Once asleep, only the wake request or reset brings the link back
   always @(posedge clk) begin
      if (rst)
         link_layer_active <= 1'b1;
      else if (sleep_req)
         link_layer_active <= 1'b0;
      else if (link_layer_wake)
         link_layer_active <= 1'b1;
   end
endmodule // link_layer_model

// ### tb/phy_ctl_bank_properties.sv
/* Port assertions for the PHY status/control bank.
   Assumes bind onto phy_ctl_bank, one clock, zero-wait APB. */
`timescale 1ns/10ps
module phy_ctl_bank_chk (
   input logic        clk,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic        pready,
   input logic        pslverr,
   input logic        state_timeout,
   input logic        bus_reset_out,
   input logic        link_layer_active,
   input logic        link_layer_wake,
   input logic        fast_arb_en,
   input logic        mixed_speed_en,
   input logic [2:0]  page_select,
   input logic [3:0]  port_select
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_no_stray_ready: assert property (!(psel && !penable) |=> !pready)
      else $error("ready without setup");
   a_unmapped_error: assert property (psel && !penable |=> pslverr == ($past(paddr) > 12'h00C || $past(paddr[1:0]) != 2'h0))
      else $error("slave error mismatch");
   a_timeout_bus_reset: assert property (state_timeout |=> bus_reset_out)
      else $error("no bus reset on time-out");
   a_wake_only_asleep: assert property (link_layer_active |=> !link_layer_wake)
      else $error("wake while link active");
   a_enables_hold: assert property (!(psel && penable && pwrite && paddr == 12'h000) |=> $stable({fast_arb_en, mixed_speed_en}))
      else $error("enable changed without write");
   a_select_hold: assert property (!(psel && penable && pwrite && paddr == 12'h008) |=> $stable({page_select, port_select}))
      else $error("select changed without write");
   a_select_write: assert property (psel && penable && pwrite && paddr == 12'h008 |=> page_select == $past(pwdata[2:0]) && port_select == $past(pwdata[7:4]))
      else $error("select write lost");
   c_bus_reset: cover property (bus_reset_out);
   c_wake: cover property (link_layer_wake);
   c_error: cover property (pslverr);
endmodule // phy_ctl_bank_chk
bind phy_ctl_bank phy_ctl_bank_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .state_timeout(state_timeout),
   .bus_reset_out(bus_reset_out), .link_layer_active(link_layer_active), .link_layer_wake(link_layer_wake),
   .fast_arb_en(fast_arb_en), .mixed_speed_en(mixed_speed_en), .page_select(page_select), .port_select(port_select));

// ### tb/test_phy_ctl_bank.sv
/* Self-checking bench for the PHY status/control bank.
   Assumes zero-wait APB slave and the link layer partner model. */
`timescale 1ns/10ps
module test_phy_ctl_bank;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleep_req = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, e, lla, brst, sra, wake, fae, mse;
   logic pwr_sense = 1, tst = 0, st = 0, idle = 0, obr = 0;
   logic [2:0] pie = 0, pb = 0, pc = 0, pd = 0, pf = 0, prs = 0, pgs;
   logic [3:0] pts;
   int failures = 0, compares = 0, n;
   always #4 clk = ~clk;
   phy_ctl_bank #(.NPORTS(3)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cable_power_sense(pwr_sense), .tree_start_timeout(tst), .state_timeout(st), .bus_idle(idle),
      .link_layer_active(lla), .other_bus_reset(obr), .port_int_enable(pie), .port_bias(pb),
      .port_connected(pc), .port_disabled(pd), .port_fault(pf), .port_resume_start(prs),
      .bus_reset_out(brst), .short_reset_active(sra), .link_layer_wake(wake), .fast_arb_en(fae),
      .mixed_speed_en(mse), .page_select(pgs), .port_select(pts));
   link_layer_model partner (.clk(clk), .rst(rst), .sleep_req(sleep_req), .link_layer_wake(wake),
      .link_layer_active(lla));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
      // A missing answer counts as a mismatch
      if (pready !== 1'b1)
         failures++;
      r = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      bus(0, a, 0);
      chk(r, x);
   endtask
   task automatic pulse_cycles(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic t_config;
      rd(12'h000, 0); rd(12'h004, 0); rd(12'h008, 0); rd(12'h00C, 32'h4);
      bus(1, 12'h000, 32'hE); bus(1, 12'h008, 32'hF7);
      // Written values land at the access edge; look once they settle
      @(negedge clk); chk({fae, mse, pgs, pts}, 9'h1FF);
      @(posedge clk); obr <= 1;
      @(posedge clk); obr <= 0;
      @(negedge clk); chk(brst, 1);
      rd(12'h000, 32'hE); rd(12'h008, 32'hF7);
   endtask
   task automatic t_flags;
      @(posedge clk); pwr_sense <= 0;
      pulse_cycles(3);
      rd(12'h004, 32'h2);
      bus(1, 12'h004, 0); rd(12'h004, 32'h2);
      bus(1, 12'h004, 32'h2); rd(12'h004, 0);
      pwr_sense <= 1; st <= 1;
      @(posedge clk); st <= 0;
      @(negedge clk); chk(brst, 1);
      rd(12'h004, 32'h4); bus(1, 12'h004, 32'h4); rd(12'h004, 0);
   endtask
   task automatic t_wake;
      // Time-out held across the clearing write: the set must win
      tst <= 1; bus(1, 12'h004, 32'h1); tst <= 0;
      rd(12'h004, 32'h1); chk(wake, 0);
      sleep_req <= 1; pulse_cycles(4); chk(wake, 1);
      sleep_req <= 0; pulse_cycles(4); chk(wake, 0); chk(lla, 1);
      bus(1, 12'h004, 32'h1); rd(12'h004, 0);
   endtask
   task automatic t_ports;
      pie <= 3'h2; pc <= 3'h2; pulse_cycles(3); rd(12'h004, 32'h8);
      bus(1, 12'h004, 32'h8); pf <= 3'h1; pulse_cycles(3); rd(12'h004, 0);
      pd <= 3'h2; pulse_cycles(3); rd(12'h004, 32'h8); bus(1, 12'h004, 32'h8);
      pb <= 3'h2; pulse_cycles(3); rd(12'h004, 0);
      prs <= 3'h4; pulse_cycles(3); rd(12'h004, 32'h8);
      bus(1, 12'h000, 32'h6); bus(1, 12'h004, 32'h8);
      prs <= 3'h1; pulse_cycles(3); rd(12'h004, 0);
   endtask
   task automatic t_short;
      bus(1, 12'h000, 32'h7); pulse_cycles(10); chk(sra, 0);
      rd(12'h000, 32'h7);
      @(posedge clk); obr <= 1;
      @(posedge clk); obr <= 0;
      rd(12'h000, 32'h6);
      bus(1, 12'h000, 32'h7); idle <= 1;
      pulse_cycles(3); chk(sra, 1);
      // Six edges since the start: three waited, three for the read
      rd(12'h00C, 32'h5); n = 6;
      do @(posedge clk); while (brst !== 1'b1 && ++n < 400);
      chk(n >= 160 && n <= 175, 1);
      rd(12'h000, 32'h6);
      bus(0, 12'h010, 0); chk(e, 1); chk(r, 0);
      bus(1, 12'h020, 32'hFFFFFFFF); chk(e, 1); rd(12'h008, 32'hF7);
   endtask
   task automatic finish_test;
      if (failures == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      pulse_cycles(20);
      rst <= 0;
      t_config; t_flags; t_wake; t_ports; t_short;
      finish_test;
   end
   // Full run needs about 350 cycles
   initial begin
      pulse_cycles(5000);
      failures++;
      finish_test;
   end
endmodule // test_phy_ctl_bank
